/* File: inc/tdma_pkg.sv */
// Purpose: constants and types for the two-channel transfer engine
// Assumes: 32-bit AHB-Lite register access, byte-wide 64K memory map
// Notes:   all register offsets are word aligned byte addresses
package tdma_pkg;
   localparam int unsigned AW         = 16;
   localparam int unsigned DW         = 8;
   localparam int unsigned NCH        = 2;
   localparam int unsigned NREQ       = 25;
   localparam int unsigned FIFO_DEPTH = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_INDEX   = 8'h00;
   localparam logic [7:0] OFS_MODE1   = 8'h04;
   localparam logic [7:0] OFS_MODE2   = 8'h08;
   localparam logic [7:0] OFS_SRC     = 8'h0C;
   localparam logic [7:0] OFS_DST     = 8'h10;
   localparam logic [7:0] OFS_CNT     = 8'h14;

   // index_and_status_reg fields
   localparam int unsigned IS_FLAG0   = 0;
   localparam int unsigned IS_SWTRIG  = 2;
   localparam int unsigned IS_BUSY0   = 4;
   localparam int unsigned IS_BANK    = 7;

   // channel_mode_first fields
   localparam int unsigned M1_EN      = 0;
   localparam int unsigned M1_BURST   = 1;
   localparam int unsigned M1_SRC_LSB = 2;
   localparam int unsigned M1_DST_LSB = 4;
   localparam int unsigned M1_AUTO    = 6;
   localparam int unsigned M1_WRLD    = 7;

   // chanN_mode_second: request source number in low bits, 0 means software only
   localparam int unsigned M2_SEL_W   = 5;

   localparam logic [7:0]    RST_MODE = 8'h00;
   localparam logic [AW-1:0] RST_WORD = 16'h0000;
   localparam logic [AW-1:0] CNT_LAST = 16'h0000;

   typedef enum logic [1:0] {
      STEP_HOLD = 2'b00,
      STEP_INC  = 2'b01,
      STEP_DEC  = 2'b10,
      STEP_RSV  = 2'b11
   } tdma_step_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_CAPT = 2'b10
   } tdma_state_e;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
   } tdma_xfer_s;
endpackage

/* File: core/tdma_ctrl.sv */
// Purpose: two-channel memory-to-memory byte transfer engine with AHB-Lite registers
// Assumes: single clock, memory read data valid one cycle after the read strobe
// Notes:   write side drains through an 8-entry buffer and may be stalled
//          busy bits name the channel that owns the engine
`timescale 1ns/1ps

module tdma_fifo #(
   parameter int unsigned WIDTH = 24,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      level;
   logic             push;
   logic             pop;

   // Level is one bit wider than the pointers so full differs from empty
   assign in_ready  = (level != (PW + 1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         case ({push, pop})
            2'b10:   level <= level + 1'b1;
            2'b01:   level <= level - 1'b1;
            default: level <= level;
         endcase
      end
   end
endmodule // tdma_fifo

module tdma_ctrl (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic                             hresp,
   output logic      [31:0]                 hrdata,
   input  wire logic [tdma_pkg::NREQ-1:0]   req_in,
   output logic                             mem_rd_en,
   output logic      [tdma_pkg::AW-1:0]     mem_rd_addr,
   input  wire logic [tdma_pkg::DW-1:0]     mem_rd_data,
   output logic                             mem_wr_en,
   output logic      [tdma_pkg::AW-1:0]     mem_wr_addr,
   output logic      [tdma_pkg::DW-1:0]     mem_wr_data,
   input  wire logic                        mem_wr_ready,
   output logic      [tdma_pkg::NCH-1:0]    irq_chan
);
   localparam int unsigned AW = tdma_pkg::AW;
   localparam int unsigned XW = $bits(tdma_pkg::tdma_xfer_s);

   // Register storage, one bank per channel
   logic [7:0]                   mode1   [tdma_pkg::NCH];
   logic [7:0]                   mode2   [tdma_pkg::NCH];
   logic [AW-1:0]                src_wk  [tdma_pkg::NCH];
   logic [AW-1:0]                dst_wk  [tdma_pkg::NCH];
   logic [AW-1:0]                cnt_wk  [tdma_pkg::NCH];
   logic [AW-1:0]                src_rl  [tdma_pkg::NCH];
   logic [AW-1:0]                dst_rl  [tdma_pkg::NCH];
   logic [AW-1:0]                cnt_rl  [tdma_pkg::NCH];
   logic                         bank;
   logic [tdma_pkg::NCH-1:0]     flag;
   logic [tdma_pkg::NCH-1:0]     pend;
   logic [tdma_pkg::NCH-1:0]     busy;
   logic [tdma_pkg::NCH-1:0]     flag_clr;

   // Bus slave state
   logic                         wr_pend;
   logic [7:0]                   wr_ofs;
   logic                         rd_take;
   logic                         wr_take;
   logic                         wr_now;
   logic [15:0]                  wd;

   // Engine state
   tdma_pkg::tdma_state_e        state;
   logic                         act;
   logic                         pick;
   logic                         pick_ok;
   logic                         capt;
   logic                         uflow;
   logic [tdma_pkg::NCH-1:0]     hw_hit;
   logic [tdma_pkg::NCH-1:0]     sw_hit;
   logic                         fifo_in_ready;
   logic                         fifo_out_valid;
   tdma_pkg::tdma_xfer_s         fifo_in;
   tdma_pkg::tdma_xfer_s         fifo_out;

   function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] m);
      case (tdma_pkg::tdma_step_e'(m))
         tdma_pkg::STEP_INC: step_addr = a + 16'h0001;
         tdma_pkg::STEP_DEC: step_addr = a - 16'h0001;
         default:            step_addr = a;
      endcase
   endfunction

   function automatic logic req_hit(input logic [tdma_pkg::NREQ-1:0] r,
                                    input logic [tdma_pkg::M2_SEL_W-1:0] sel);
      req_hit = 1'b0;
      for (int i = 0; i < tdma_pkg::NREQ; i++) begin
         if (sel == tdma_pkg::M2_SEL_W'(i + 1)) begin
            req_hit = r[i];
         end
      end
   endfunction

   // AHB-Lite slave: zero wait except one stall when a read follows a write
   assign rd_take   = hsel && htrans[1] && !hwrite && hready;
   assign wr_take   = hsel && htrans[1] && hwrite && hready;
   assign hreadyout = !(wr_pend && hsel && htrans[1] && !hwrite);
   assign hresp     = 1'b0;
   assign wr_now    = wr_pend;
   assign wd        = hwdata[15:0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend <= 1'b0;
         wr_ofs  <= 8'h00;
      end else begin
         wr_pend <= wr_take;
         if (wr_take) begin
            wr_ofs <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take) begin
         case (haddr[7:0])
            tdma_pkg::OFS_INDEX: hrdata <= {24'h00_0000,
                                             bank, 1'b0,
                                             busy, 2'b00,
                                             flag};
            tdma_pkg::OFS_MODE1: hrdata <= {24'h00_0000, mode1[bank]};
            tdma_pkg::OFS_MODE2: hrdata <= {24'h00_0000, mode2[bank]};
            tdma_pkg::OFS_SRC:   hrdata <= {16'h0000, src_wk[bank]};
            tdma_pkg::OFS_DST:   hrdata <= {16'h0000, dst_wk[bank]};
            tdma_pkg::OFS_CNT:   hrdata <= {16'h0000, cnt_wk[bank]};
            default:             hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Bank select and mode registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bank <= 1'b0;
         for (int c = 0; c < tdma_pkg::NCH; c++) begin
            mode1[c] <= tdma_pkg::RST_MODE;
            mode2[c] <= tdma_pkg::RST_MODE;
         end
      end else if (wr_now) begin
         case (wr_ofs)
            tdma_pkg::OFS_INDEX: bank <= wd[tdma_pkg::IS_BANK];
            tdma_pkg::OFS_MODE1: mode1[bank] <= wd[7:0];
            tdma_pkg::OFS_MODE2: mode2[bank] <= wd[7:0];
            default: ;
         endcase
      end
   end

   // Request detection: hardware source or software trigger to selected bank
   generate
      for (genvar c = 0; c < tdma_pkg::NCH; c++) begin : g_req
         assign hw_hit[c] = req_hit(req_in, mode2[c][tdma_pkg::M2_SEL_W-1:0]);
         assign sw_hit[c] = wr_now && wr_ofs == tdma_pkg::OFS_INDEX
                            && wd[tdma_pkg::IS_SWTRIG] && wd[tdma_pkg::IS_BANK] == c;
      end
   endgenerate

   // Pending requests; a new request wins over the clear on service start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend <= '0;
      end else begin
         for (int c = 0; c < tdma_pkg::NCH; c++) begin
            if (hw_hit[c] || sw_hit[c]) begin
               pend[c] <= 1'b1;
            end else if (state == tdma_pkg::ST_IDLE && pick_ok && pick == c) begin
               pend[c] <= 1'b0;
            end
         end
      end
   end

   // Fixed priority, channel 0 first
   always_comb begin
      pick    = 1'b0;
      pick_ok = 1'b0;
      if (pend[0] && mode1[0][tdma_pkg::M1_EN]) begin
         pick_ok = 1'b1;
      end else if (pend[1] && mode1[1][tdma_pkg::M1_EN]) begin
         pick    = 1'b1;
         pick_ok = 1'b1;
      end
   end

   // Busy per channel; a stalled read still counts as busy
   always_comb begin
      busy = '0;
      if (state != tdma_pkg::ST_IDLE) begin
         busy[act] = 1'b1;
      end
   end

   // Write one to clear; only a write to the index register counts
   assign flag_clr = (wr_now && wr_ofs == tdma_pkg::OFS_INDEX)
                     ? wd[tdma_pkg::IS_FLAG0 +: tdma_pkg::NCH] : '0;

   // Buffer space is checked before the read so captured data is never dropped
   assign mem_rd_en   = state == tdma_pkg::ST_READ && fifo_in_ready;
   assign mem_rd_addr = src_wk[act];
   assign capt        = state == tdma_pkg::ST_CAPT;
   assign uflow       = capt && cnt_wk[act] == tdma_pkg::CNT_LAST;
   assign fifo_in     = '{addr: dst_wk[act], data: mem_rd_data};

   // Engine: read cycle then capture cycle per byte
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= tdma_pkg::ST_IDLE;
         act   <= 1'b0;
      end else begin
         case (state)
            tdma_pkg::ST_IDLE: begin
               if (pick_ok) begin
                  act   <= pick;
                  state <= tdma_pkg::ST_READ;
               end
            end
            tdma_pkg::ST_READ: begin
               if (fifo_in_ready) begin
                  state <= tdma_pkg::ST_CAPT;
               end
            end
            tdma_pkg::ST_CAPT: begin
               if (mode1[act][tdma_pkg::M1_BURST] && !uflow
                   && mode1[act][tdma_pkg::M1_EN]) begin
                  state <= tdma_pkg::ST_READ;
               end else begin
                  state <= tdma_pkg::ST_IDLE;
               end
            end
            default: state <= tdma_pkg::ST_IDLE;
         endcase
      end
   end

   // Working and reload registers; a bus write overrides an engine step
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < tdma_pkg::NCH; c++) begin
            src_wk[c] <= tdma_pkg::RST_WORD;
            dst_wk[c] <= tdma_pkg::RST_WORD;
            cnt_wk[c] <= tdma_pkg::RST_WORD;
            src_rl[c] <= tdma_pkg::RST_WORD;
            dst_rl[c] <= tdma_pkg::RST_WORD;
            cnt_rl[c] <= tdma_pkg::RST_WORD;
         end
      end else begin
         if (capt) begin
            if (uflow && mode1[act][tdma_pkg::M1_AUTO]) begin
               src_wk[act] <= src_rl[act];
               dst_wk[act] <= dst_rl[act];
               cnt_wk[act] <= cnt_rl[act];
            end else begin
               src_wk[act] <= step_addr(src_wk[act],
                  mode1[act][tdma_pkg::M1_SRC_LSB +: 2]);
               dst_wk[act] <= step_addr(dst_wk[act],
                  mode1[act][tdma_pkg::M1_DST_LSB +: 2]);
               cnt_wk[act] <= cnt_wk[act] - 16'h0001;
            end
         end
         if (wr_now) begin
            case (wr_ofs)
               tdma_pkg::OFS_SRC: begin
                  src_rl[bank] <= wd;
                  if (mode1[bank][tdma_pkg::M1_WRLD]) begin
                     src_wk[bank] <= wd;
                  end
               end
               tdma_pkg::OFS_DST: begin
                  dst_rl[bank] <= wd;
                  if (mode1[bank][tdma_pkg::M1_WRLD]) begin
                     dst_wk[bank] <= wd;
                  end
               end
               tdma_pkg::OFS_CNT: begin
                  cnt_rl[bank] <= wd;
                  if (mode1[bank][tdma_pkg::M1_WRLD]) begin
                     cnt_wk[bank] <= wd;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Underflow flags: write one to clear, a new underflow wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag     <= '0;
         irq_chan <= '0;
      end else begin
         for (int c = 0; c < tdma_pkg::NCH; c++) begin
            irq_chan[c] <= uflow && act == c;
            if (uflow && act == c) begin
               flag[c] <= 1'b1;
            end else if (flag_clr[c]) begin
               flag[c] <= 1'b0;
            end
         end
      end
   end

   // Write side drains the buffer at the memory's own pace
   tdma_fifo #(
      .WIDTH (XW),
      .DEPTH (tdma_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (capt),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in),
      .out_valid (fifo_out_valid),
      .out_ready (mem_wr_ready),
      .out_data  (fifo_out)
   );

   assign mem_wr_en   = fifo_out_valid;
   assign mem_wr_addr = fifo_out.addr;
   assign mem_wr_data = fifo_out.data;
endmodule // tdma_ctrl

/* File: sim/tdma_ctrl_props.sv */
// Purpose: concurrent checks on the transfer engine ports
// Assumes: one clock domain, async active high reset
// Notes:   bound into every tdma_ctrl instance
`timescale 1ns/1ps
module tdma_ctrl_props (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        mem_rd_en,
   input wire logic        mem_wr_en,
   input wire logic [15:0] mem_wr_addr,
   input wire logic [7:0]  mem_wr_data,
   input wire logic        mem_wr_ready,
   input wire logic [1:0]  irq_chan
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic acc_rd;
   assign acc_rd = hsel & htrans[1] & hready & !hwrite;
   bus_okay_a: assert property (hresp == 1'b0)
      else $error("response not okay");
   wait_one_a: assert property (!hreadyout |=> hreadyout)
      else $error("wait state too long");
   rdata_hold_a: assert property (!acc_rd |=> $stable(hrdata))
      else $error("read data moved");
   byte_two_a: assert property (mem_rd_en |=> !mem_rd_en)
      else $error("read strobes too close");
   push_out_a: assert property (mem_rd_en |-> ##2 mem_wr_en)
      else $error("byte not offered for write");
   wr_hold_a: assert property (mem_wr_en && !mem_wr_ready |=>
      mem_wr_en && $stable(mem_wr_addr) && $stable(mem_wr_data))
      else $error("write dropped while stalled");
   irq0_pulse_a: assert property (irq_chan[0] |=> !irq_chan[0])
      else $error("irq 0 too long");
   irq1_pulse_a: assert property (irq_chan[1] |=> !irq_chan[1])
      else $error("irq 1 too long");
endmodule // tdma_ctrl_props

bind tdma_ctrl tdma_ctrl_props u_props (.clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
   .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
   .mem_wr_ready(mem_wr_ready), .irq_chan(irq_chan));

/* File: sim/tdma_mem_model.sv */
// Purpose: byte memory on the far side of the engine
// Assumes: read data due the cycle after the strobe
// Notes:   unwritten bytes read as address xor key
`timescale 1ns/1ps
module tdma_mem_model (
   input wire logic        clk,
   input wire logic        rd_en,
   input wire logic [15:0] rd_addr,
   output logic      [7:0] rd_data,
   input wire logic        wr_en,
   input wire logic [15:0] wr_addr,
   input wire logic [7:0]  wr_data,
   output logic            wr_ready,
   input wire logic        stall,
   input wire logic [7:0]  key
);
   logic [7:0] wmem [logic [15:0]];
   initial rd_data = 8'h00;
   initial wr_ready = 1'b0;
   // Data only valid after a strobe, toggles otherwise
   always @(posedge clk) begin
      if (rd_en)
         rd_data <= wmem.exists(rd_addr) ? wmem[rd_addr] : rd_addr[7:0] ^ key;
      else
         rd_data <= ~rd_data;
      wr_ready <= !stall && ($urandom % 4 != 0);
      if (wr_en && wr_ready)
         wmem[wr_addr] = wr_data;
   end
endmodule // tdma_mem_model

/* File: sim/two_channel_dma_controller_tb.sv */
// Purpose: self-checking bench for the transfer engine
// Assumes: hready tied to the slave's own hreadyout
// Notes:   expected bytes come from the address xor key pattern
`timescale 1ns/1ps
module two_channel_dma_controller_tb;
   logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, stall = 0;
   logic        hready, hreadyout, hresp, mem_rd_en, mem_wr_en, mem_wr_ready;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0]  htrans = 0, irq_chan;
   logic [2:0]  hsize = 3'b010;
   logic [24:0] req_in = 0;
   logic [15:0] mem_rd_addr, mem_wr_addr, s0, s1, radq[$];
   logic [15:0] d0 = 16'h4000, d1 = 16'h6000;
   logic [7:0]  mem_rd_data, mem_wr_data, key;
   int          error_cnt = 0, n_compared = 0, irq0 = 0, irq1 = 0, rdn = 0, r0;
   assign hready = hreadyout;
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      if (irq_chan[0] === 1'b1) irq0++;
      if (irq_chan[1] === 1'b1) irq1++;
      if (mem_rd_en === 1'b1) begin
         rdn++;
         radq.push_back(mem_rd_addr);
      end
   end
   tdma_ctrl dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_in(req_in),
      .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
      .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
      .mem_wr_ready(mem_wr_ready), .irq_chan(irq_chan));
   tdma_mem_model mem (.clk(clk), .rd_en(mem_rd_en), .rd_addr(mem_rd_addr),
      .rd_data(mem_rd_data), .wr_en(mem_wr_en), .wr_addr(mem_wr_addr),
      .wr_data(mem_wr_data), .wr_ready(mem_wr_ready), .stall(stall), .key(key));
   task complete_run;
      if (error_cnt == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task hang;
      error_cnt++;
      $display("[ERR] %0t wait ran out", $time);
      complete_run;
   endtask
   task edge_rdy;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) hang;
         @(posedge clk);
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      edge_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      edge_rdy;
      q = hrdata;
   endtask
   task cfg(input logic b, input logic [7:0] m1, m2, input logic [15:0] s, d, c);
      ahb(1, tdma_pkg::OFS_INDEX, {24'h00_0000, b, 7'h00});
      ahb(1, tdma_pkg::OFS_MODE1, 32'(m1));
      ahb(1, tdma_pkg::OFS_MODE2, 32'(m2));
      ahb(1, tdma_pkg::OFS_SRC, 32'(s));
      ahb(1, tdma_pkg::OFS_DST, 32'(d));
      ahb(1, tdma_pkg::OFS_CNT, 32'(c));
   endtask
   task wait_idle;
      int n;
      n = 0;
      repeat (3) @(posedge clk);
      do begin
         n++;
         if (n > 60) hang;
         ahb(0, tdma_pkg::OFS_INDEX, 0);
      end while (q[5:4] !== 2'b00 || mem_wr_en !== 1'b0);
   endtask
   function automatic logic [31:0] pat(input logic [15:0] a);
      return 32'(a[7:0] ^ key);
   endfunction
   initial begin
      r0 = $urandom(79);
      key = 8'($urandom);
      s0 = 16'h1000 + 16'($urandom % 256);
      s1 = 16'h2100 + 16'($urandom % 256);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      ahb(1, 8'h18, 32'hFFFF_FFFF);
      for (int i = 0; i < 7; i++) begin
         ahb(0, 8'(4 * i), 0);
         chk(q, 0);
      end
      // Every source line, single bytes, auto reload every third
      cfg(0, 8'hD5, 8'h01, s0, d0, 16'h0002);
      for (int k = 0; k < tdma_pkg::NREQ; k++) begin
         ahb(1, tdma_pkg::OFS_MODE2, 32'(k + 1));
         req_in[k] <= 1'b1;
         @(posedge clk);
         req_in <= '0;
         wait_idle;
         ahb(0, tdma_pkg::OFS_CNT, 0);
         chk(q, 32'(2 - ((k + 1) % 3)));
      end
      for (int k = 0; k < 3; k++)
         chk(32'(mem.wmem[d0 + 16'(k)]), pat(s0 + 16'(k)));
      chk(irq0, 8);
      chk(irq1, 0);
      ahb(0, tdma_pkg::OFS_SRC, 0);
      chk(q, 32'(s0 + 16'h0001));
      ahb(0, tdma_pkg::OFS_INDEX, 0);
      chk(32'(q[1:0]), 1);
      ahb(1, tdma_pkg::OFS_INDEX, 32'h0000_0081);
      ahb(0, tdma_pkg::OFS_SRC, 0);
      chk(q, 0);
      ahb(0, tdma_pkg::OFS_INDEX, 0);
      chk(32'(q[7:0]), 32'h0000_0080);
      // Burst, source down, dest held, fills the buffer while stalled
      cfg(1, 8'h8B, 8'h00, s1, d1, 16'h000B);
      stall <= 1'b1;
      r0 = rdn;
      ahb(1, tdma_pkg::OFS_INDEX, 32'h0000_0084);
      repeat (60) @(posedge clk);
      chk(rdn - r0, 8);
      ahb(0, tdma_pkg::OFS_INDEX, 0);
      chk(32'(q[5]), 1);
      stall <= 1'b0;
      wait_idle;
      chk(32'(q[1:0]), 2);
      chk(rdn - r0, 12);
      chk(32'(mem.wmem[d1]), pat(s1 - 16'h000B));
      chk(irq1, 1);
      // Both channels asked in the same cycle
      cfg(0, 8'h81, 8'h01, s0, d0, 16'h0000);
      cfg(1, 8'h81, 8'h02, s1, d1, 16'h0000);
      radq.delete();
      req_in[1:0] <= 2'b11;
      @(posedge clk);
      req_in <= '0;
      wait_idle;
      chk(32'(radq[0]), 32'(s0));
      chk(32'(radq[1]), 32'(s1));
      // Write without load keeps the working value; flags clear on a one
      ahb(1, tdma_pkg::OFS_INDEX, 32'h0000_0003);
      ahb(1, tdma_pkg::OFS_MODE1, 32'h0000_0000);
      ahb(1, tdma_pkg::OFS_SRC, 32'h0000_1234);
      ahb(0, tdma_pkg::OFS_SRC, 0);
      chk(q, 32'(s0));
      ahb(0, tdma_pkg::OFS_INDEX, 0);
      chk(32'(q[7:0]), 0);
      // Disabled channel keeps its software request pending
      ahb(1, tdma_pkg::OFS_INDEX, 32'h0000_0004);
      repeat (10) @(posedge clk);
      chk(32'(radq.size()), 2);
      ahb(1, tdma_pkg::OFS_MODE1, 32'h0000_0001);
      wait_idle;
      chk(32'(radq[2]), 32'(s0));
      chk(irq0, 9);
      chk(irq1, 2);
      complete_run;
   end
   initial begin
      repeat (60000) @(posedge clk);
      hang;
   end
endmodule // two_channel_dma_controller_tb
